// file: pkg/rtc_irq_pkg.sv
package rtc_irq_pkg;

    // ----------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ----------------------------------------------------------------
    localparam logic [5:0] IDX_FLAGS = 6'h0E;
    localparam logic [5:0] IDX_CTRL = 6'h0F;
    localparam logic [5:0] IDX_STATUS = 6'h10;
    localparam logic [5:0] IDX_MASK = 6'h11;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int BIT_UPDATE = 5;
    localparam int BIT_PERIODIC = 4;
    localparam int BIT_ALARM = 3;
    localparam int BIT_STOP = 1;
    localparam int BIT_CNT_RESET = 0;
    localparam int BIT_VLOSS = 1;

    localparam logic [7:0] CTRL_WMASK = 8'h3B;
    localparam logic [7:0] FLAG_MASK = 8'h3A;

    // ----------------------------------------------------------------
    // Values after reset
    // ----------------------------------------------------------------
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] FLAGS_RST = 8'h02;
    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam logic [7:0] MASK_RST = 8'h00;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int IRQ_HOLD_NS = 7800000;
    localparam int IRQ_HOLD_CYC = IRQ_HOLD_NS / CLK_PERIOD_NS;

endpackage

// file: rtl/irq_hold_timer.sv
`timescale 1ns/1ns
`default_nettype none

module irq_hold_timer
#(
    parameter int CYCLES = 78000
)
(
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    // Control
    input wire logic i_start,
    input wire logic i_cancel,
    // Status
    output logic o_active
);

    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LOAD = CW'(CYCLES - 1);

    typedef struct packed
    {
        logic active;
        logic [CW-1:0] count;
    } tmr_t;

    tmr_t q;
    tmr_t d;

    // ----------------------------------------------------------------
    // Countdown; a fresh event restarts the full hold time
    // ----------------------------------------------------------------
    always_comb
    begin
        d = q;
        if (i_cancel)
        begin
            d.active = 1'b0;
            d.count = '0;
        end
        else if (i_start)
        begin
            d.active = 1'b1;
            d.count = LOAD;
        end
        else if (q.active)
        begin
            if (q.count == '0)
                d.active = 1'b0;
            else
                d.count = q.count - CW'(1);
        end
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_nrst)
            q <= '0;
        else
            q <= d;
    end

    assign o_active = q.active;

endmodule

`default_nettype wire

// file: rtl/rtc_irq_ctrl.sv
`timescale 1ns/1ns
`default_nettype none

module rtc_irq_ctrl
    import rtc_irq_pkg::*;
#(
    parameter int HOLD_CYCLES = IRQ_HOLD_CYC
)
(
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Event pulses from the clock, timer and supply monitor
    input wire logic i_update_event,
    input wire logic i_periodic_event,
    input wire logic i_alarm_event,
    input wire logic i_voltage_loss,
    // Run control towards the counter chain
    output logic o_stop_req,
    output logic o_counter_reset_req,
    // Open-drain interrupt pin
    output logic o_int_n_out,
    output logic o_int_oe_n,
    // System interrupt
    output logic o_irq
);

    localparam int AW = $clog2(HOLD_CYCLES + 2);

    typedef struct packed
    {
        logic [7:0] ctrl;
        logic [7:0] flags;
        logic [7:0] flags_prev;
        logic [7:0] status;
        logic [7:0] mask;
        logic alm_act;
        logic drive;
        logic irq;
        logic [31:0] rdata;
        logic [AW-1:0] upd_age;
        logic [AW-1:0] per_age;
    } state_t;

    state_t q;
    state_t d;

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    function automatic logic hit(input logic [7:0] addr, input logic [5:0] idx);
        hit = (addr[7:2] == idx);
    endfunction

    function automatic logic [AW-1:0] age_next(input logic [AW-1:0] a, input logic start);
        if (start)
            age_next = AW'(1);
        else if (a == {AW{1'b1}})
            age_next = a;
        else
            age_next = a + AW'(1);
    endfunction

    logic mapped;
    logic wr;
    logic setup_rd;
    logic [7:0] wbyte;
    logic [7:0] flag_set;
    logic [7:0] flag_clr;
    logic [7:0] rises;
    logic upd_start;
    logic per_start;
    logic upd_on;
    logic per_on;

    assign mapped = hit(i_paddr, IDX_FLAGS) || hit(i_paddr, IDX_CTRL)
        || hit(i_paddr, IDX_STATUS) || hit(i_paddr, IDX_MASK);
    assign wr = i_psel && i_penable && i_pwrite && mapped;
    assign setup_rd = i_psel && !i_penable && !i_pwrite;
    assign wbyte = i_pwdata[7:0];

    // Zero wait states: every access ends in its first access cycle
    assign o_pready = 1'b1;
    assign o_pslverr = i_psel && i_penable && !mapped;

    // ----------------------------------------------------------------
    // Flags
    // ----------------------------------------------------------------
    always_comb
    begin
        flag_set = 8'h00;
        flag_set[BIT_UPDATE] = i_update_event;
        flag_set[BIT_PERIODIC] = i_periodic_event;
        flag_set[BIT_ALARM] = i_alarm_event;
        flag_set[BIT_VLOSS] = i_voltage_loss;
    end

    // Only a written zero clears a flag; set wins over a same-cycle clear
    assign flag_clr = (wr && hit(i_paddr, IDX_FLAGS)) ? (~wbyte & FLAG_MASK) : 8'h00;
    assign rises = q.flags & ~q.flags_prev & FLAG_MASK;

    assign upd_start = rises[BIT_UPDATE] && q.ctrl[BIT_UPDATE];
    assign per_start = rises[BIT_PERIODIC] && q.ctrl[BIT_PERIODIC];

    // ----------------------------------------------------------------
    // Hold timers for the self-clearing sources
    // ----------------------------------------------------------------
    irq_hold_timer #(
        .CYCLES(HOLD_CYCLES)
    ) u_upd_hold (
        .i_clk_sys(i_clk_sys),
        .i_nrst(i_nrst),
        .i_start(upd_start),
        .i_cancel(!q.ctrl[BIT_UPDATE]),
        .o_active(upd_on)
    );

    irq_hold_timer #(
        .CYCLES(HOLD_CYCLES)
    ) u_per_hold (
        .i_clk_sys(i_clk_sys),
        .i_nrst(i_nrst),
        .i_start(per_start),
        .i_cancel(!q.ctrl[BIT_PERIODIC]),
        .o_active(per_on)
    );

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        d = q;
        d.flags = ((q.flags & ~flag_clr) | flag_set) & FLAG_MASK;
        d.flags_prev = q.flags;
        if (wr && hit(i_paddr, IDX_CTRL))
            d.ctrl = wbyte & CTRL_WMASK;
        if (wr && hit(i_paddr, IDX_MASK))
            d.mask = wbyte & FLAG_MASK;
        d.status = q.status;
        if (wr && hit(i_paddr, IDX_STATUS))
            d.status = q.status & ~wbyte;
        d.status = (d.status | rises) & FLAG_MASK;
        // Alarm holds the pin with no timeout while its flag and its enable stay set
        if (!q.flags[BIT_ALARM] || !q.ctrl[BIT_ALARM])
            d.alm_act = 1'b0;
        else if (rises[BIT_ALARM])
            d.alm_act = 1'b1;
        // Gating by the enable here keeps the pin one clock behind a write
        d.drive = (upd_on && q.ctrl[BIT_UPDATE])
            || (per_on && q.ctrl[BIT_PERIODIC])
            || (q.alm_act && q.ctrl[BIT_ALARM]);
        d.irq = |(q.status & q.mask);
        if (setup_rd)
        begin
            d.rdata = 32'h0000_0000;
            if (hit(i_paddr, IDX_FLAGS))
                d.rdata[7:0] = q.flags;
            else if (hit(i_paddr, IDX_CTRL))
                d.rdata[7:0] = q.ctrl & CTRL_WMASK;
            else if (hit(i_paddr, IDX_STATUS))
                d.rdata[7:0] = q.status;
            else if (hit(i_paddr, IDX_MASK))
                d.rdata[7:0] = q.mask;
        end
        d.upd_age = age_next(q.upd_age, upd_start);
        d.per_age = age_next(q.per_age, per_start);
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    // Undefined power-up contents are pinned to zero, except the supply-loss flag, which resets set, so no stray pulse
    // reaches the pin before software sets the enables
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_nrst)
        begin
            q <= '0;
            q.ctrl <= CTRL_RST;
            q.flags <= FLAGS_RST;
            q.flags_prev <= FLAGS_RST;
            q.status <= STATUS_RST;
            q.mask <= MASK_RST;
        end
        else
            q <= d;
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign o_prdata = q.rdata;
    assign o_stop_req = q.ctrl[BIT_STOP];
    assign o_counter_reset_req = q.ctrl[BIT_CNT_RESET];
    assign o_int_n_out = 1'b0;
    assign o_int_oe_n = !q.drive;
    assign o_irq = q.irq;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_nrst);

    logic ctrl_wr;
    assign ctrl_wr = wr && hit(i_paddr, IDX_CTRL);

    property p_ctrl_fields;
        ctrl_wr |=> (q.ctrl[BIT_UPDATE] == $past(i_pwdata[5]))
            && (q.ctrl[BIT_ALARM] == $past(i_pwdata[3]))
            && (o_stop_req == $past(i_pwdata[1]));
    endproperty
    a_ctrl_fields: assert property (p_ctrl_fields)
        else $error("control field not stored at its bit");

    property p_ctrl_reserved;
        setup_rd && hit(i_paddr, IDX_CTRL) |=> o_prdata[7:6] == 2'b00 && !o_prdata[2];
    endproperty
    a_ctrl_reserved: assert property (p_ctrl_reserved)
        else $error("reserved control bit read as one");

    property p_upd_assert;
        upd_start && !ctrl_wr |=> ##1 !o_int_oe_n;
    endproperty
    a_upd_assert: assert property (p_upd_assert)
        else $error("update event did not pull the pin low");

    property p_upd_hold;
        $fell(upd_on) && $past(q.ctrl[BIT_UPDATE]) |-> q.upd_age == AW'(HOLD_CYCLES + 1);
    endproperty
    a_upd_hold: assert property (p_upd_hold)
        else $error("update assertion length differs from hold time");

    property p_per_hold;
        per_on |-> q.per_age <= AW'(HOLD_CYCLES);
    endproperty
    a_per_hold: assert property (p_per_hold)
        else $error("periodic assertion outlived hold time");

    property p_per_assert;
        per_start && !ctrl_wr |=> ##1 !o_int_oe_n;
    endproperty
    a_per_assert: assert property (p_per_assert)
        else $error("periodic event did not pull the pin low");

    property p_alm_assert;
        rises[BIT_ALARM] && q.ctrl[BIT_ALARM] && !ctrl_wr && !flag_clr[BIT_ALARM]
            |=> q.alm_act ##1 !o_int_oe_n;
    endproperty
    a_alm_assert: assert property (p_alm_assert)
        else $error("alarm event did not pull the pin low");

    property p_alm_persist;
        $fell(q.alm_act) |-> !$past(q.flags[BIT_ALARM]) || !$past(q.ctrl[BIT_ALARM]);
    endproperty
    a_alm_persist: assert property (p_alm_persist)
        else $error("alarm assertion ended with flag and enable set");

    property p_pin_or;
        ##1 o_int_oe_n == !($past(upd_on && q.ctrl[BIT_UPDATE])
            || $past(per_on && q.ctrl[BIT_PERIODIC]) || $past(q.alm_act && q.ctrl[BIT_ALARM]));
    endproperty
    a_pin_or: assert property (p_pin_or)
        else $error("pin is not the OR of gated sources");

    property p_flag_zero_only;
        wr && hit(i_paddr, IDX_FLAGS) && i_pwdata[BIT_ALARM] && !q.flags[BIT_ALARM]
            && !i_alarm_event |=> !q.flags[BIT_ALARM];
    endproperty
    a_flag_zero_only: assert property (p_flag_zero_only)
        else $error("written one set an event flag");

    property p_od_level;
        o_int_n_out == 1'b0;
    endproperty
    a_od_level: assert property (p_od_level)
        else $error("open-drain pin drove high");

    property p_enables_off;
        ctrl_wr && (i_pwdata[5:3] == 3'b000) |=> ##1 o_int_oe_n;
    endproperty
    a_enables_off: assert property (p_enables_off)
        else $error("pin still driven after enables cleared");

    c_upd_pulse: cover property (upd_start ##1 upd_on);
    c_alarm_hold: cover property (q.alm_act ##1 !q.flags[BIT_ALARM]);
    c_irq_out: cover property ($rose(o_irq));
    c_unmapped: cover property (o_pslverr);

endmodule

`default_nettype wire

// file: sim/host_int_line.sv
`timescale 1ns/1ns
`default_nettype none

module host_int_line
(
    // Pin drive from the device
    input wire logic i_int_n_out,
    input wire logic i_int_oe_n,
    // Level seen by the host
    output logic o_pin
);
    // ----------------------------------------
    // Board pull-up
    // ----------------------------------------
    // A released line reads the pull-up level, never a held value
    assign o_pin = (i_int_oe_n === 1'b0) ? i_int_n_out : 1'b1;
endmodule

`default_nettype wire

// file: sim/tb_rtc_interrupt_output_control.sv
`timescale 1ns/1ns
`default_nettype none

module tb_rtc_interrupt_output_control
    import rtc_irq_pkg::*;
;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    // Short hold keeps the run brief; expectations follow it
    localparam int HOLD = 20;
    localparam logic [7:0] A_FLG = {IDX_FLAGS, 2'b00};
    localparam logic [7:0] A_CTL = {IDX_CTRL, 2'b00};
    localparam logic [7:0] A_STS = {IDX_STATUS, 2'b00};
    localparam logic [7:0] A_MSK = {IDX_MASK, 2'b00};
    logic clk;
    logic nrst;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [2:0] ev;
    logic vloss;
    logic stop_req;
    logic cnt_rst_req;
    logic int_n_out;
    logic int_oe_n;
    logic irq;
    logic pin;
    int err_count;
    int comparisons;

    rtc_irq_ctrl #(.HOLD_CYCLES(HOLD)) DUT
    (
        .i_clk_sys(clk),
        .i_nrst(nrst),
        .i_psel(psel),
        .i_penable(penable),
        .i_pwrite(pwrite),
        .i_paddr(paddr),
        .i_pwdata(pwdata),
        .o_prdata(prdata),
        .o_pready(pready),
        .o_pslverr(pslverr),
        .i_update_event(ev[2]),
        .i_periodic_event(ev[1]),
        .i_alarm_event(ev[0]),
        .i_voltage_loss(vloss),
        .o_stop_req(stop_req),
        .o_counter_reset_req(cnt_rst_req),
        .o_int_n_out(int_n_out),
        .o_int_oe_n(int_oe_n),
        .o_irq(irq)
    );

    host_int_line host
    (
        .i_int_n_out(int_n_out),
        .i_int_oe_n(int_oe_n),
        .o_pin(pin)
    );

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic complete_run();
        $display("comparisons %0d err_count %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
        comparisons++;
        if (got !== exp)
        begin
            $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
            err_count++;
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50)
        begin
            $display("wrong value at %0t: no pready", $time);
            err_count++;
            complete_run();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string msg);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        check(r, exp, msg);
    endtask

    task automatic pulse(input logic [2:0] m);
        @(posedge clk);
        ev <= m;
        @(posedge clk);
        ev <= 3'h0;
    endtask

    // Returns at the first edge that samples the level, or at the bound
    task automatic wait_pin(input logic lvl, input int lim, output int n);
        n = 0;
        while (pin !== lvl && n < lim)
        begin
            @(posedge clk);
            n++;
        end
    endtask

    initial
    begin
        #(64'd2000000);
        $display("wrong value at %0t: run hung", $time);
        err_count++;
        complete_run();
    end

    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial
    begin
        logic [31:0] r;
        logic e;
        logic [2:0] m;
        int n;
        err_count = 0;
        comparisons = 0;
        nrst = 1'b0;
        {psel, penable, pwrite} = 3'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        ev = 3'h0;
        vloss = 1'b0;
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        check(32'(pin), 32'h1, "idle pin");
        rdc(A_CTL, 32'h0, "ctrl reset");
        rdc(A_FLG, 32'h02, "flags reset");
        apb(1'b0, 8'hFC, 32'h0, r, e);
        check(32'(e), 32'h1, "unmapped error");
        check(r, 32'h0, "unmapped data");
        wr(A_CTL, 32'hFFFFFFFF);
        rdc(A_CTL, 32'h3B, "ctrl fields");
        check({30'h0, stop_req, cnt_rst_req}, 32'h3, "run outputs");
        wr(A_CTL, 32'h0);
        wr(A_CTL, 32'h20);
        pulse(3'h4);
        wait_pin(1'b0, 6, n);
        check(32'(pin), 32'h0, "update low");
        wait_pin(1'b1, HOLD + 10, n);
        check(n, HOLD, "update hold");
        rdc(A_FLG, 32'h22, "update flag");
        wr(A_FLG, 32'hFF);
        rdc(A_FLG, 32'h22, "one ignored");
        wr(A_FLG, 32'h02);
        rdc(A_FLG, 32'h02, "zero clears");
        wr(A_CTL, 32'h10);
        pulse(3'h2);
        wait_pin(1'b0, 6, n);
        check(32'(pin), 32'h0, "timer low");
        wait_pin(1'b1, HOLD + 10, n);
        check(32'(n <= HOLD), 32'h1, "timer hold");
        wr(A_FLG, 32'h02);
        for (int i = 0; i < 3; i++)
        begin
            m = 3'h4 >> i;
            wr(A_CTL, {26'h0, m, 3'h0});
            pulse(m);
            wait_pin(1'b0, 6, n);
            check(32'(pin), 32'h0, "gated on");
            wr(A_CTL, 32'h0);
            wait_pin(1'b1, 3, n);
            check(32'(pin), 32'h1, "cancel");
            wr(A_FLG, 32'h02);
            pulse(m);
            wait_pin(1'b0, HOLD + 10, n);
            check(32'(pin), 32'h1, "gated off");
            rdc(A_FLG, {26'h0, m, 3'h2}, "poll flag");
            wr(A_FLG, 32'h02);
        end
        wr(A_CTL, 32'h28);
        pulse(3'h5);
        wait_pin(1'b0, 6, n);
        repeat (HOLD + 10) @(posedge clk);
        check(32'(pin), 32'h0, "alarm persists");
        rdc(A_FLG, 32'h2A, "both flags");
        wr(A_FLG, 32'h22);
        wait_pin(1'b1, 4, n);
        check(32'(pin), 32'h1, "alarm cleared");
        rdc(A_FLG, 32'h22, "alarm only");
        // Status and mask towards the system interrupt
        rdc(A_STS, 32'h38, "status");
        check(32'(irq), 32'h0, "masked");
        wr(A_MSK, 32'h08);
        repeat (2) @(posedge clk);
        check(32'(irq), 32'h1, "irq set");
        wr(A_STS, 32'h08);
        repeat (2) @(posedge clk);
        check(32'(irq), 32'h0, "irq clear");
        rdc(A_STS, 32'h30, "w1c");
        // Supply-loss flag: cleared by a written zero, set again by its event
        wr(A_FLG, 32'h00);
        rdc(A_FLG, 32'h00, "vloss clears");
        @(posedge clk);
        vloss <= 1'b1;
        @(posedge clk);
        vloss <= 1'b0;
        repeat (2) @(posedge clk);
        rdc(A_FLG, 32'h02, "vloss set");
        rdc(A_STS, 32'h32, "vloss status");
        complete_run();
    end
endmodule

`default_nettype wire
